// File: inc/fsp_pkg.sv
// constants, register map and carrier types of the framed serial port
// assumes a classic wishbone master on clk_i and a separate link clock
package fsp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam int unsigned ADR_W      = 5;
   localparam logic [4:0]  REG_CTRL   = 5'h00;
   localparam logic [4:0]  REG_CLKDIV = 5'h04;
   localparam logic [4:0]  REG_TXDATA = 5'h08;
   localparam logic [4:0]  REG_RXDATA = 5'h0c;
   localparam logic [4:0]  REG_STATUS = 5'h10;

   // status bit positions
   localparam int unsigned STAT_TX_PEND = 0;
   localparam int unsigned STAT_RX_VAL  = 1;
   localparam int unsigned STAT_RX_OVR  = 2;
   localparam int unsigned STAT_TX_ACT  = 3;

   ////////////////////////////////////////////////////////////////////////////
   // control word; packed order puts tx_clk_out in bit 0
   typedef struct packed {
      logic enable;
      logic rx_edge_fall;
      logic tx_edge_fall;
      logic rx_fs_out;
      logic rx_clk_out;
      logic tx_fs_out;
      logic tx_clk_out;
   } fsp_cfg_t;

   localparam int unsigned CTRL_W  = 7;
   localparam fsp_cfg_t    CFG_RST = 7'h00;

   // synchronised pin levels
   typedef struct packed {
      logic tx_clk;
      logic tx_fs;
      logic rx_clk;
      logic rx_fs;
      logic rx_data;
   } fsp_pins_t;

   localparam int unsigned PINS_W = 5;

   ////////////////////////////////////////////////////////////////////////////
   // generated bit clock divider and its legal range
   localparam int unsigned DIV_W         = 8;
   localparam int unsigned BCLK_MIN_KHZ  = 512;
   localparam int unsigned BCLK_MAX_KHZ  = 8192;

   // bus cycles a reset is stretched by, so the slower link clock sees it
   localparam int unsigned RST_CNT_W = 8;
   localparam logic [7:0]  RST_HOLD  = 8'h80;

endpackage : fsp_pkg

// File: src/fsp_sync.sv
// two flip-flop level synchroniser, one per bit of the vector
// assumes the input is a level that stays put for several destination clocks
`timescale 1ns/1ps
module fsp_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   always_comb
   begin
      meta_nxt = rst_i ? '0 : d_i;
      q_nxt    = rst_i ? '0 : meta_r;
   end

   always_ff @(posedge clk_i)
   begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
   end

   assign q_o = q_r;

endmodule : fsp_sync

// File: src/fsp_port.sv
// framed serial port: wishbone registers on clk_i, serial engine on lnk_clk_i
// assumes pins pass two flip-flops in the link domain; config changed only
// while the port is disabled
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module fsp_port #(
   parameter int unsigned WORD_W       = 8,
   parameter int unsigned LINK_CLK_KHZ = 12500
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [4:0]  adr_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   input  wire logic        we_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   output logic             ack_o,
   input  wire logic        lnk_clk_i,
   input  wire logic        tx_bit_clock_i,
   output logic             tx_bit_clock_o,
   output logic             tx_bit_clock_oe_o,
   input  wire logic        tx_frame_sync_i,
   output logic             tx_frame_sync_o,
   output logic             tx_frame_sync_oe_o,
   output logic             tx_serial_out_o,
   output logic             tx_serial_out_oe_o,
   input  wire logic        rx_bit_clock_i,
   output logic             rx_bit_clock_o,
   output logic             rx_bit_clock_oe_o,
   input  wire logic        rx_frame_sync_i,
   output logic             rx_frame_sync_o,
   output logic             rx_frame_sync_oe_o,
   input  wire logic        rx_serial_in_i
);

   localparam int unsigned CW = $clog2(WORD_W);
   // generated clock = link / (2*(div+1)); min rounds up, max rounds down
   localparam int DIV_MIN_I = (LINK_CLK_KHZ + 2 * fsp_pkg::BCLK_MAX_KHZ - 1)
                              / (2 * fsp_pkg::BCLK_MAX_KHZ) - 1;
   localparam int DIV_MAX_I = LINK_CLK_KHZ / (2 * fsp_pkg::BCLK_MIN_KHZ) - 1;
   localparam logic [fsp_pkg::DIV_W-1:0] DIV_MIN =
      fsp_pkg::DIV_W'((DIV_MIN_I < 0) ? 0 : DIV_MIN_I);
   localparam logic [fsp_pkg::DIV_W-1:0] DIV_MAX = fsp_pkg::DIV_W'(DIV_MAX_I);
   localparam logic [CW-1:0] LAST_BIT = CW'(WORD_W - 1);

   typedef enum logic {TX_IDLE, TX_SHIFT} fsp_tx_st_t;

   ////////////////////////////////////////////////////////////////////////////
   // bus side state
   fsp_pkg::fsp_cfg_t           cfg_r, cfg_nxt;
   logic [fsp_pkg::DIV_W-1:0]   div_r, div_nxt;
   logic [WORD_W-1:0]           tx_word_r, tx_word_nxt;
   logic                        tx_tgl_r, tx_tgl_nxt;
   logic [WORD_W-1:0]           rx_word_r, rx_word_nxt;
   logic                        rx_seen_r, rx_seen_nxt;
   logic                        rx_val_r, rx_val_nxt;
   logic                        rx_ovr_r, rx_ovr_nxt;
   logic                        ack_r, ack_nxt;
   logic [31:0]                 dat_r, dat_nxt;
   logic                        tx_ack_s, rx_tgl_s, tx_act_s;
   logic                        wb_req, tx_pend;
   logic [fsp_pkg::RST_CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;
   logic                        rst_hold_r, rst_hold_nxt;

   // link side state
   logic                        lnk_rst;
   fsp_pkg::fsp_cfg_t           cfg_l;
   logic [fsp_pkg::DIV_W-1:0]   div_l;
   fsp_pkg::fsp_pins_t          pin_s;
   logic                        tx_tgl_l;
   logic [fsp_pkg::DIV_W-1:0]   gen_cnt_r, gen_cnt_nxt;
   logic                        gen_clk_r, gen_clk_nxt;
   logic                        txc_prev_r, rxc_prev_r;
   fsp_tx_st_t                  tx_st_r, tx_st_nxt;
   logic [WORD_W-1:0]           tx_sh_r, tx_sh_nxt;
   logic [CW-1:0]               tx_cnt_r, tx_cnt_nxt;
   logic                        tx_seen_r, tx_seen_nxt;
   logic                        tx_fs_r, tx_fs_nxt;
   logic                        tx_bit_r, tx_bit_nxt;
   logic                        tx_oe_r, tx_oe_nxt;
   logic                        rx_act_r, rx_act_nxt;
   logic [WORD_W-1:0]           rx_sh_r, rx_sh_nxt;
   logic [CW-1:0]               rx_cnt_r, rx_cnt_nxt;
   logic [WORD_W-1:0]           rx_word_l_r, rx_word_l_nxt;
   logic                        rx_tgl_r, rx_tgl_nxt;
   logic [CW-1:0]               rxg_cnt_r, rxg_cnt_nxt;
   logic                        rx_fs_r, rx_fs_nxt;
   logic [3:0]                  oe_r, oe_nxt;
   logic                        txc_lvl, rxc_lvl, tx_launch, rx_sample;
   logic                        tx_has, tx_start, rx_start;

   ////////////////////////////////////////////////////////////////////////////
   // reset stretch: a short bus reset would slip between two link clocks
   always_comb
   begin
      rst_cnt_nxt  = (rst_cnt_r == '0) ? '0 : rst_cnt_r - 1'b1;
      rst_hold_nxt = rst_cnt_r != '0;
      if (rst_i)
      begin
         rst_cnt_nxt  = fsp_pkg::RST_HOLD;
         rst_hold_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      rst_cnt_r  <= rst_cnt_nxt;
      rst_hold_r <= rst_hold_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // crossings
   fsp_sync #(.W(1)) u_rst_sync (
      .clk_i (lnk_clk_i), .rst_i (1'b0), .d_i (rst_hold_r), .q_o (lnk_rst));
   // cfg and div are quasi-static: software changes them only while disabled
   fsp_sync #(.W(fsp_pkg::CTRL_W)) u_cfg_sync (
      .clk_i (lnk_clk_i), .rst_i (lnk_rst), .d_i (cfg_r), .q_o (cfg_l));
   fsp_sync #(.W(fsp_pkg::DIV_W)) u_div_sync (
      .clk_i (lnk_clk_i), .rst_i (lnk_rst), .d_i (div_r), .q_o (div_l));
   fsp_sync #(.W(fsp_pkg::PINS_W)) u_pin_sync (
      .clk_i (lnk_clk_i), .rst_i (lnk_rst),
      .d_i   ({tx_bit_clock_i, tx_frame_sync_i, rx_bit_clock_i,
               rx_frame_sync_i, rx_serial_in_i}),
      .q_o   (pin_s));
   fsp_sync #(.W(1)) u_txreq_sync (
      .clk_i (lnk_clk_i), .rst_i (lnk_rst), .d_i (tx_tgl_r), .q_o (tx_tgl_l));
   fsp_sync #(.W(3)) u_back_sync (
      .clk_i (clk_i), .rst_i (rst_hold_r),
      .d_i   ({tx_seen_r, rx_tgl_r, tx_st_r == TX_SHIFT}),
      .q_o   ({tx_ack_s, rx_tgl_s, tx_act_s}));

   ////////////////////////////////////////////////////////////////////////////
   // wishbone registers
   assign wb_req  = cyc_i & stb_i & ~ack_r;
   assign tx_pend = tx_tgl_r != tx_ack_s;

   always_comb
   begin
      cfg_nxt     = cfg_r;
      div_nxt     = div_r;
      tx_word_nxt = tx_word_r;
      tx_tgl_nxt  = tx_tgl_r;
      rx_word_nxt = rx_word_r;
      rx_seen_nxt = rx_seen_r;
      rx_val_nxt  = rx_val_r;
      rx_ovr_nxt  = rx_ovr_r;
      ack_nxt     = wb_req;
      dat_nxt     = '0;
      if (wb_req && !we_i)
      begin
         case (adr_i)
            fsp_pkg::REG_CTRL:   dat_nxt = 32'(cfg_r);
            fsp_pkg::REG_CLKDIV: dat_nxt = 32'(div_r);
            fsp_pkg::REG_TXDATA: dat_nxt = 32'(tx_word_r);
            fsp_pkg::REG_RXDATA:
            begin
               dat_nxt    = 32'(rx_word_r);
               rx_val_nxt = 1'b0;
            end
            fsp_pkg::REG_STATUS:
            begin
               dat_nxt[fsp_pkg::STAT_TX_PEND] = tx_pend;
               dat_nxt[fsp_pkg::STAT_RX_VAL]  = rx_val_r;
               dat_nxt[fsp_pkg::STAT_RX_OVR]  = rx_ovr_r;
               dat_nxt[fsp_pkg::STAT_TX_ACT]  = tx_act_s;
            end
            default: dat_nxt = '0;
         endcase
      end
      if (wb_req && we_i && sel_i[0])
      begin
         case (adr_i)
            fsp_pkg::REG_CTRL: cfg_nxt = fsp_pkg::fsp_cfg_t'(dat_i[fsp_pkg::CTRL_W-1:0]);
            fsp_pkg::REG_CLKDIV:
            begin
               // generated clocks never leave the legal bit clock range
               if (dat_i[fsp_pkg::DIV_W-1:0] < DIV_MIN)
                  div_nxt = DIV_MIN;
               else if (dat_i[fsp_pkg::DIV_W-1:0] > DIV_MAX)
                  div_nxt = DIV_MAX;
               else
                  div_nxt = dat_i[fsp_pkg::DIV_W-1:0];
            end
            fsp_pkg::REG_TXDATA:
            begin
               // a word already waiting is kept; the new one is dropped
               if (!tx_pend)
               begin
                  tx_word_nxt = dat_i[WORD_W-1:0];
                  tx_tgl_nxt  = ~tx_tgl_r;
               end
            end
            fsp_pkg::REG_STATUS:
               if (dat_i[fsp_pkg::STAT_RX_OVR])
                  rx_ovr_nxt = 1'b0;
            default: ;
         endcase
      end
      // a new word wins over a read or a clear in the same cycle
      if (rx_tgl_s != rx_seen_r)
      begin
         rx_seen_nxt = rx_tgl_s;
         rx_word_nxt = rx_word_l_r;
         rx_ovr_nxt  = rx_ovr_nxt | rx_val_nxt;
         rx_val_nxt  = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_r     <= fsp_pkg::CFG_RST;
         div_r     <= DIV_MAX;
         tx_word_r <= '0;
         tx_tgl_r  <= 1'b0;
         rx_word_r <= '0;
         rx_seen_r <= 1'b0;
         rx_val_r  <= 1'b0;
         rx_ovr_r  <= 1'b0;
         ack_r     <= 1'b0;
         dat_r     <= '0;
      end
      else
      begin
         cfg_r     <= cfg_nxt;
         div_r     <= div_nxt;
         tx_word_r <= tx_word_nxt;
         tx_tgl_r  <= tx_tgl_nxt;
         rx_word_r <= rx_word_nxt;
         rx_seen_r <= rx_seen_nxt;
         rx_val_r  <= rx_val_nxt;
         rx_ovr_r  <= rx_ovr_nxt;
         ack_r     <= ack_nxt;
         dat_r     <= dat_nxt;
      end
   end

   assign ack_o = ack_r;
   assign dat_o = dat_r;

   ////////////////////////////////////////////////////////////////////////////
   // link engine; bit clocks are oversampled, so input clocks must stay
   // below a third of the link clock
   assign txc_lvl   = cfg_l.tx_clk_out ? gen_clk_r : pin_s.tx_clk;
   assign rxc_lvl   = cfg_l.rx_clk_out ? gen_clk_r : pin_s.rx_clk;
   assign tx_launch = cfg_l.tx_edge_fall ? (txc_prev_r & ~txc_lvl)
                                         : (~txc_prev_r & txc_lvl);
   assign rx_sample = cfg_l.rx_edge_fall ? (rxc_prev_r & ~rxc_lvl)
                                         : (~rxc_prev_r & rxc_lvl);
   assign tx_has    = tx_tgl_l != tx_seen_r;
   assign tx_start  = tx_has & (cfg_l.tx_fs_out | pin_s.tx_fs);
   assign rx_start  = cfg_l.rx_fs_out ? (rxg_cnt_r == '0) : pin_s.rx_fs;

   always_comb
   begin
      gen_cnt_nxt   = gen_cnt_r + 1'b1;
      gen_clk_nxt   = gen_clk_r;
      tx_st_nxt     = tx_st_r;
      tx_sh_nxt     = tx_sh_r;
      tx_cnt_nxt    = tx_cnt_r;
      tx_seen_nxt   = tx_seen_r;
      tx_fs_nxt     = tx_fs_r;
      tx_bit_nxt    = tx_bit_r;
      tx_oe_nxt     = tx_oe_r;
      rx_act_nxt    = rx_act_r;
      rx_sh_nxt     = rx_sh_r;
      rx_cnt_nxt    = rx_cnt_r;
      rx_word_l_nxt = rx_word_l_r;
      rx_tgl_nxt    = rx_tgl_r;
      rxg_cnt_nxt   = rxg_cnt_r;
      rx_fs_nxt     = rx_fs_r;
      oe_nxt        = {cfg_l.rx_fs_out, cfg_l.rx_clk_out,
                       cfg_l.tx_fs_out, cfg_l.tx_clk_out};
      if (gen_cnt_r >= div_l)
      begin
         gen_cnt_nxt = '0;
         gen_clk_nxt = ~gen_clk_r & cfg_l.enable;
      end
      if (!cfg_l.enable)
      begin
         tx_st_nxt  = TX_IDLE;
         tx_fs_nxt  = 1'b0;
         tx_oe_nxt  = 1'b0;
         tx_bit_nxt = 1'b1;
         rx_act_nxt = 1'b0;
         rx_fs_nxt  = 1'b0;
      end
      else
      begin
         if (tx_launch)
         begin
            case (tx_st_r)
               TX_IDLE:
               begin
                  tx_fs_nxt = 1'b0;
                  tx_oe_nxt = 1'b0;
                  tx_bit_nxt = 1'b1;
                  if (tx_start)
                  begin
                     // frame sync rides with the first bit, msb first
                     tx_fs_nxt   = cfg_l.tx_fs_out;
                     tx_bit_nxt  = tx_word_r[WORD_W-1];
                     tx_oe_nxt   = ~tx_word_r[WORD_W-1];
                     tx_sh_nxt   = tx_word_r << 1;
                     tx_cnt_nxt  = '0;
                     tx_seen_nxt = tx_tgl_l;
                     tx_st_nxt   = TX_SHIFT;
                  end
               end
               TX_SHIFT:
               begin
                  tx_fs_nxt = 1'b0;
                  if (tx_cnt_r == LAST_BIT)
                  begin
                     tx_oe_nxt = 1'b0;
                     tx_bit_nxt = 1'b1;
                     tx_st_nxt = TX_IDLE;
                  end
                  else
                  begin
                     tx_bit_nxt = tx_sh_r[WORD_W-1];
                     tx_oe_nxt  = ~tx_sh_r[WORD_W-1];
                     tx_sh_nxt  = tx_sh_r << 1;
                     tx_cnt_nxt = tx_cnt_r + 1'b1;
                  end
               end
               default: tx_st_nxt = TX_IDLE;
            endcase
         end
         if (rx_sample)
         begin
            rxg_cnt_nxt = (rxg_cnt_r == LAST_BIT) ? '0 : rxg_cnt_r + 1'b1;
            rx_fs_nxt   = cfg_l.rx_fs_out & (rxg_cnt_nxt == '0);
            rx_sh_nxt   = {rx_sh_r[WORD_W-2:0], pin_s.rx_data};
            // a sync in mid word restarts the word
            if (rx_start)
            begin
               rx_act_nxt = 1'b1;
               rx_cnt_nxt = CW'(1);
            end
            else if (rx_act_r)
            begin
               if (rx_cnt_r == LAST_BIT)
               begin
                  rx_word_l_nxt = rx_sh_nxt;
                  rx_tgl_nxt    = ~rx_tgl_r;
                  rx_act_nxt    = 1'b0;
               end
               else
                  rx_cnt_nxt = rx_cnt_r + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge lnk_clk_i)
   begin
      if (lnk_rst)
      begin
         gen_cnt_r   <= '0;
         gen_clk_r   <= 1'b0;
         txc_prev_r  <= 1'b0;
         rxc_prev_r  <= 1'b0;
         tx_st_r     <= TX_IDLE;
         tx_sh_r     <= '0;
         tx_cnt_r    <= '0;
         tx_seen_r   <= 1'b0;
         tx_fs_r     <= 1'b0;
         tx_bit_r    <= 1'b1;
         tx_oe_r     <= 1'b0;
         rx_act_r    <= 1'b0;
         rx_sh_r     <= '0;
         rx_cnt_r    <= '0;
         rx_word_l_r <= '0;
         rx_tgl_r    <= 1'b0;
         rxg_cnt_r   <= '0;
         rx_fs_r     <= 1'b0;
         oe_r        <= '0;
      end
      else
      begin
         gen_cnt_r   <= gen_cnt_nxt;
         gen_clk_r   <= gen_clk_nxt;
         txc_prev_r  <= txc_lvl;
         rxc_prev_r  <= rxc_lvl;
         tx_st_r     <= tx_st_nxt;
         tx_sh_r     <= tx_sh_nxt;
         tx_cnt_r    <= tx_cnt_nxt;
         tx_seen_r   <= tx_seen_nxt;
         tx_fs_r     <= tx_fs_nxt;
         tx_bit_r    <= tx_bit_nxt;
         tx_oe_r     <= tx_oe_nxt;
         rx_act_r    <= rx_act_nxt;
         rx_sh_r     <= rx_sh_nxt;
         rx_cnt_r    <= rx_cnt_nxt;
         rx_word_l_r <= rx_word_l_nxt;
         rx_tgl_r    <= rx_tgl_nxt;
         rxg_cnt_r   <= rxg_cnt_nxt;
         rx_fs_r     <= rx_fs_nxt;
         oe_r        <= oe_nxt;
      end
   end

   assign tx_bit_clock_o     = gen_clk_r;
   assign rx_bit_clock_o     = gen_clk_r;
   assign tx_bit_clock_oe_o  = oe_r[0];
   assign tx_frame_sync_oe_o = oe_r[1];
   assign rx_bit_clock_oe_o  = oe_r[2];
   assign rx_frame_sync_oe_o = oe_r[3];
   assign tx_frame_sync_o    = tx_fs_r;
   assign rx_frame_sync_o    = rx_fs_r;
   // open drain: the bit register is low only while oe pulls the wire low
   assign tx_serial_out_o    = tx_bit_r;
   assign tx_serial_out_oe_o = tx_oe_r;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   AST_TXFS_RST:     assert property (@(posedge lnk_clk_i) disable iff (lnk_rst)
      $fell(lnk_rst) |-> !tx_frame_sync_oe_o) else $error("tx sync not input after reset");
   AST_TXFS_ALIGN:   assert property (@(posedge lnk_clk_i) disable iff (lnk_rst)
      $rose(tx_st_r == TX_SHIFT) |-> tx_frame_sync_o == cfg_l.tx_fs_out)
      else $error("tx sync not with first bit");
   AST_TXFS_ONE_BIT: assert property (@(posedge lnk_clk_i) disable iff (lnk_rst)
      tx_frame_sync_o && tx_launch |=> !tx_frame_sync_o)
      else $error("tx sync longer than one bit");
   AST_RXFS_RST:     assert property (@(posedge lnk_clk_i) disable iff (lnk_rst)
      $fell(lnk_rst) |-> !rx_frame_sync_oe_o) else $error("rx sync not input after reset");
   AST_TXCLK_RST:    assert property (@(posedge lnk_clk_i) disable iff (lnk_rst)
      $fell(lnk_rst) |-> !tx_bit_clock_oe_o) else $error("tx clock not input after reset");
   AST_DIV_RANGE:    assert property (@(posedge clk_i) disable iff (rst_i)
      div_r >= DIV_MIN && div_r <= DIV_MAX) else $error("bit clock divider out of range");
   AST_TX_SHIFT:     assert property (@(posedge lnk_clk_i) disable iff (lnk_rst)
      $changed(tx_serial_out_oe_o) |-> $past(tx_launch) || $past(!cfg_l.enable))
      else $error("tx data moved off a launch edge");
   AST_TX_EDGE:      assert property (@(posedge lnk_clk_i) disable iff (lnk_rst)
      $rose(tx_st_r == TX_SHIFT) |-> $past(txc_lvl) != $past(cfg_l.tx_edge_fall))
      else $error("tx launched on wrong edge");
   AST_RX_EDGE:      assert property (@(posedge lnk_clk_i) disable iff (lnk_rst)
      $changed(rx_cnt_r) |-> $past(rxc_lvl) != $past(cfg_l.rx_edge_fall))
      else $error("rx sampled on wrong edge");
   AST_RXCLK_RST:    assert property (@(posedge lnk_clk_i) disable iff (lnk_rst)
      $fell(lnk_rst) |-> !rx_bit_clock_oe_o) else $error("rx clock not input after reset");
   AST_RX_CAPTURE:   assert property (@(posedge lnk_clk_i) disable iff (lnk_rst)
      $changed(rx_tgl_r) |-> $past(rx_sample) && rx_word_l_r == rx_sh_r)
      else $error("rx word not taken on a sample edge");

   COV_TX_OUT: cover property (@(posedge lnk_clk_i) disable iff (lnk_rst)
      $rose(tx_frame_sync_o));
   COV_TX_FALL: cover property (@(posedge lnk_clk_i) disable iff (lnk_rst)
      cfg_l.tx_edge_fall && $rose(tx_st_r == TX_SHIFT));
   COV_RX_WORD: cover property (@(posedge clk_i) disable iff (rst_i)
      $rose(rx_val_r));

endmodule : fsp_port

// File: verif/fsp_far_end.sv
// far-end framer model: bit clock, frame sync and rx data source, tx capture
// assumes the bench resolves each shared pin wire from the port's enables
`timescale 1ns/1ps
module fsp_far_end (
   input  wire logic       run_i,
   input  wire logic       act_fall_i,
   input  wire logic [7:0] word_i,
   input  wire logic       bclk_i,
   input  wire logic       fs_i,
   input  wire logic       sdat_i,
   output logic            pclk_o,
   output logic            pfs_o,
   output logic            pdat_o,
   output logic [7:0]      got_o,
   output int              got_cnt_o
);
   int n   = 8;
   int cnt = 0;
   initial {pclk_o, pfs_o, pdat_o} = 3'h1;
   // 1 MHz bit clock, still between bursts
   always
   begin
      wait (run_i);
      #500 pclk_o = ~pclk_o;
   end
   // sample before updating, so a sync seen here marks the bit now on the wire
   always @(bclk_i)
   begin
      if (bclk_i == !act_fall_i)
      begin
         if (fs_i) n = 0;
         if (n < 8)
         begin
            got_o = {got_o[6:0], sdat_i};
            n++;
            if (n == 8) got_cnt_o++;
         end
         pfs_o  = run_i && cnt == 0;
         pdat_o = cnt < 8 ? word_i[7 - cnt] : !pdat_o;
         cnt    = cnt == 8 ? 0 : cnt + 1;
      end
   end
endmodule : fsp_far_end

// File: verif/test_fsp_port.sv
// self-checking bench for the framed serial port against a far-end framer
// assumes fsp_port and fsp_far_end are compiled before it
`timescale 1ns/1ps
module test_fsp_port;
   logic        clk_i = 1'h0, rst_i = 1'h1, lnk_clk_i = 1'h0;
   logic [4:0]  adr_i = '0;
   logic [31:0] dat_i = '0, dat_o;
   logic [3:0]  sel_i = '0;
   logic        we_i = 1'h0, cyc_i = 1'h0, stb_i = 1'h0, ack_o;
   logic        run = 1'h0, act_fall = 1'h0, pclk, pfs, pdat, sd_o;
   logic        tclk_o, tclk_oe, tfs_o, tfs_oe, sd_oe, rclk_o, rclk_oe, rfs_o, rfs_oe;
   logic [7:0]  rx_word = '0, got, w;
   int          got_cnt, num_errors = 0, samples_checked = 0;
   logic [31:0] rdq[$];
   logic [7:0]  txq[$];
   wire         tclk = tclk_oe ? tclk_o : pclk;
   wire         rclk = rclk_oe ? rclk_o : pclk;
   wire         tfs  = tfs_oe ? tfs_o : pfs;
   wire         rfs  = rfs_oe ? rfs_o : pfs;
   wire         sdat = sd_oe ? sd_o : 1'h1; // open drain, pulled high when released
   wire [4:0]   oes  = {tclk_oe, tfs_oe, rclk_oe, rfs_oe, sd_oe};

   fsp_port fsp_port_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
      .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
      .lnk_clk_i(lnk_clk_i), .tx_bit_clock_i(tclk), .tx_bit_clock_o(tclk_o),
      .tx_bit_clock_oe_o(tclk_oe), .tx_frame_sync_i(tfs), .tx_frame_sync_o(tfs_o),
      .tx_frame_sync_oe_o(tfs_oe), .tx_serial_out_o(sd_o), .tx_serial_out_oe_o(sd_oe),
      .rx_bit_clock_i(rclk), .rx_bit_clock_o(rclk_o), .rx_bit_clock_oe_o(rclk_oe),
      .rx_frame_sync_i(rfs), .rx_frame_sync_o(rfs_o), .rx_frame_sync_oe_o(rfs_oe),
      .rx_serial_in_i(pdat));
   fsp_far_end fsp_far_end_inst (.run_i(run), .act_fall_i(act_fall), .word_i(rx_word),
      .bclk_i(tclk), .fs_i(tfs), .sdat_i(sdat), .pclk_o(pclk), .pfs_o(pfs), .pdat_o(pdat),
      .got_o(got), .got_cnt_o(got_cnt));

   ////////////////////////////////////////////////////////////////////////////////
   initial forever #2 clk_i = ~clk_i;
   initial
   begin
      #13;
      forever #40 lnk_clk_i = ~lnk_clk_i;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic wb(input logic [4:0] a, input logic wr, input logic [31:0] d,
                     input logic [31:0] e);
      int t = 0;
      if (!wr) rdq.push_back(e);
      {adr_i, we_i, dat_i, sel_i, cyc_i, stb_i} <= {a, wr, d, 4'h1, 2'h3};
      do @(posedge clk_i); while (ack_o !== 1'h1 && ++t < 50);
      if (t >= 50) num_errors++;
      {cyc_i, stb_i, we_i} <= 3'h0;
      @(posedge clk_i);
   endtask : wb

   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
   endtask : settle

   // frames take tens of microseconds, so the wait is bounded well above that
   task automatic wait_q();
      int t = 0;
      while (txq.size() != 0 && t++ < 20000) @(posedge clk_i);
   endtask : wait_q

   task automatic complete_run();
      if (num_errors == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run

   always @(posedge clk_i)
      if (ack_o === 1'h1 && !we_i && rdq.size() != 0) chk(dat_o, rdq.pop_front());
   always @(got_cnt)
      chk({24'h0, got}, {24'h0, txq.size() != 0 ? txq.pop_front() : 8'hxx});

   initial
   begin
      #300000;
      num_errors++;
      complete_run();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(81635));
      settle(10);
      rst_i <= 1'h0;
      @(posedge clk_i);
      // the link side leaves reset only after the stretched bus reset
      settle(200);
      chk({27'h0, oes}, '0);
      wb(fsp_pkg::REG_CTRL, 1'h0, '0, '0);
      wb(fsp_pkg::REG_CLKDIV, 1'h0, '0, 32'h0b);
      wb(5'h14, 1'h0, '0, '0);
      w = 8'($urandom);
      wb(fsp_pkg::REG_CLKDIV, 1'h1, {24'h0, w}, '0);
      wb(fsp_pkg::REG_CLKDIV, 1'h0, '0, {24'h0, w > 8'h0b ? 8'h0b : w});
      wb(fsp_pkg::REG_CLKDIV, 1'h1, 32'h0b, '0);
      // own clocks and syncs, launch on rising, far end samples on falling
      act_fall <= 1'h1;
      wb(fsp_pkg::REG_CTRL, 1'h1, 32'h4f, '0);
      settle(200);
      chk({27'h0, oes}, 32'h1e);
      w = 8'($urandom);
      txq.push_back(w);
      wb(fsp_pkg::REG_TXDATA, 1'h1, {24'h0, w}, '0);
      wait_q();
      wb(fsp_pkg::REG_CTRL, 1'h0, '0, 32'h4f);
      wb(fsp_pkg::REG_CTRL, 1'h1, '0, '0);
      // far end supplies clock and syncs; port launches and samples on falling
      settle(200);
      act_fall <= 1'h0;
      rx_word <= 8'($urandom);
      wb(fsp_pkg::REG_CTRL, 1'h1, 32'h70, '0);
      settle(200);
      chk({27'h0, oes}, '0);
      w = 8'($urandom);
      txq.push_back(w);
      txq.push_back(8'hff);
      wb(fsp_pkg::REG_TXDATA, 1'h1, {24'h0, w}, '0);
      settle(100);
      run <= 1'h1;
      wait_q();
      run <= 1'h0;
      settle(500);
      wb(fsp_pkg::REG_STATUS, 1'h0, '0, 32'h06);
      wb(fsp_pkg::REG_RXDATA, 1'h0, '0, {24'h0, rx_word});
      chk(32'(txq.size() + rdq.size()), '0);
      complete_run();
   end
endmodule : test_fsp_port
